// [hdl/flash_id_device.sv]
// Purpose: Identification readout logic of a serial flash, clocked by the link clock
// Assumes: Host keeps its own phase order and zero address fields
// Notes:   Select high or RESET clears all frame state asynchronously
`timescale 1ns/1ps
// Function
// - 90h, zero address, then maker and device
// - Output on falling edge, MSB first
// - Select low starts, select high stops output
// - 92h address and data two bits per clock
// - Host sends mode byte with upper nibble ones
// - Dual read 4 dummies, 8 when field long
// - Quad read 6 dummies, 8 when field long
// - 94h: four dummies, address, data four-wide
// - Dual and quad reads alternate bytes endlessly
// - Dual and quad reads take 32-bit address with ADDR4_MODE set, else 24-bit
// - Dual and quad reads only in single-wire mode
// - 4Bh: 4 or 5 dummy bytes, 64-bit number
// - 9Fh returns maker, type, capacity bytes
// - 9Fh accepted in both command modes
// - 5Ah: address, 8 dummies, data at clock 40
// - Low address byte picks table start byte
// - 5Ah single-wire only, always 24-bit address
module flash_id_device #(
  parameter logic [7:0]    MFR_ID_VAL    = 8'h5c,                 // Arbitrary value
  parameter logic [7:0]    DEV_ID_VAL    = 8'h17,                 // Arbitrary value
  parameter logic [7:0]    TYPE_VAL      = 8'h61,                 // Arbitrary value
  parameter logic [7:0]    CAPACITY_VAL  = 8'h19,                 // Arbitrary value
  parameter logic [63:0]   UNIQUE_ID     = 64'h0123_4567_89ab_cdef, // Arbitrary value
  parameter logic [2047:0] PARAM_TABLE   = {256{8'hff}}           // Byte 0 in bits 7:0
) (
  // Reset
  input  wire logic       RESET,
  // Link
  flash_id_if.dev         LINK,
  // Configuration straps
  input  wire logic [1:0] DUMMY_COUNT_FIELD,
  input  wire logic       FOUR_WIRE_COMMAND_MODE,
  input  wire logic       ADDR4_MODE,
  // Status
  output logic      [7:0] LAST_OPCODE
);
  import flash_id_pkg::*;

  logic       [3:0] cfg_meta_q;
  logic       [3:0] cfg_q;
  logic             addr4;
  logic             quad;
  logic       [1:0] dcf;
  logic             frame_rst;
  logic       [7:0] table_mem [0:TABLE_BYTES-1];
  phase_t           ph_q;
  phase_t           ph_d;
  phase_t           ph_next;
  logic       [5:0] cnt_q;
  logic       [5:0] cnt_d;
  logic       [5:0] ph_len;
  logic             last;
  logic             accept;
  logic       [2:0] lane;
  logic       [2:0] out_w;
  logic       [7:0] opc_q;
  logic       [7:0] opc_d;
  logic       [7:0] op_in;
  logic       [7:0] op_now;
  logic       [7:0] addr_q;
  logic       [7:0] addr_d;
  logic       [7:0] idx_q;
  logic       [7:0] tbl_byte;
  logic       [7:0] cur_byte;
  logic       [7:0] sh_q;
  logic       [3:0] left_q;
  logic       [3:0] dout_q;
  logic       [3:0] oe_q;

  // Byte that starts a new output byte; idx counts bytes already begun
  function automatic logic [7:0] byte_at(input logic [7:0] op, input logic [7:0] idx,
                                         input logic [7:0] tbl);
    logic [63:0] uid;
    uid = UNIQUE_ID >> {3'h7 - idx[2:0], 3'h0};
    if (op == OP_THREE_BYTE_ID)
      return (idx == 8'h00) ? MFR_ID_VAL : (idx == 8'h01) ? TYPE_VAL :
             (idx == 8'h02) ? CAPACITY_VAL : FILL_BYTE;
    if (op == OP_UNIQUE_ID)
      return uid[7:0];
    if (op == OP_PARAM_TABLE)
      return tbl;
    return idx[0] ? DEV_ID_VAL : MFR_ID_VAL;
  endfunction

  for (genvar i = 0; i < TABLE_BYTES; i++) begin : g_tbl
    assign table_mem[i] = PARAM_TABLE[i*BYTE_W +: BYTE_W];
  end

  // Straps are quasi-static; they are resynchronised on the link clock
  always_ff @(posedge LINK.sclk or posedge RESET) begin
    if (RESET) begin
      cfg_meta_q <= 4'h0;
      cfg_q      <= 4'h0;
    end else begin
      cfg_meta_q <= {ADDR4_MODE, FOUR_WIRE_COMMAND_MODE, DUMMY_COUNT_FIELD};
      cfg_q      <= cfg_meta_q;
    end
  end

  assign addr4 = cfg_q[3];
  assign quad  = cfg_q[2];
  assign dcf   = cfg_q[1:0];

  // The clock stops between frames, so select itself ends the frame
  assign frame_rst = RESET | LINK.select_n;

  // Input side: everything is sampled on the rising edge
  assign lane    = ph_lane(opc_q, ph_q, quad);
  assign op_in   = shift_in(opc_q, LINK.io, lane);
  assign op_now  = (ph_q == PH_OPC) ? op_in : opc_q;
  assign ph_len  = ph_clocks(op_now, ph_q, addr4, dcf, quad);
  assign last    = (cnt_q == ph_len - 6'h01);
  assign accept  = op_ok(op_in, quad);
  assign ph_next = next_active(op_now, ph_q, addr4, dcf, quad);

  // Unknown or disallowed instructions park until select rises
  assign ph_d = (!last || ph_q inside {PH_DATA, PH_IGNORE}) ? ph_q :
                (ph_q == PH_OPC && !accept) ? PH_IGNORE : ph_next;
  assign cnt_d = (ph_d != ph_q || ph_q inside {PH_DATA, PH_IGNORE}) ? 6'h00 : cnt_q + 6'h01;
  assign opc_d = (ph_q == PH_OPC) ? op_in : opc_q;
  // Only the low address byte matters: it is the table start byte
  assign addr_d = (ph_q == PH_ADDR) ? shift_in(addr_q, LINK.io, lane) : addr_q;

  always_ff @(posedge LINK.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      ph_q   <= PH_OPC;
      cnt_q  <= 6'h00;
      opc_q  <= 8'h00;
      addr_q <= 8'h00;
    end else begin
      ph_q   <= ph_d;
      cnt_q  <= cnt_d;
      opc_q  <= opc_d;
      addr_q <= addr_d;
    end
  end

  always_ff @(posedge LINK.sclk or posedge RESET) begin
    if (RESET)
      LAST_OPCODE <= 8'h00;
    else if (ph_q == PH_OPC && last && !LINK.select_n)
      LAST_OPCODE <= op_in;
  end

  // Output side: data phase is entered at the rising edge of the last input
  // clock, so the first bits leave on that same clock's falling edge
  assign out_w    = ph_lane(opc_q, PH_DATA, quad);
  assign tbl_byte = table_mem[8'(addr_q + idx_q)];
  assign cur_byte = (left_q == 4'h0) ? byte_at(opc_q, idx_q, tbl_byte) : sh_q;

  always_ff @(negedge LINK.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      dout_q <= 4'h0;
      oe_q   <= 4'h0;
      sh_q   <= 8'h00;
      left_q <= 4'h0;
      idx_q  <= 8'h00;
    end else if (ph_q == PH_DATA) begin
      dout_q <= pins(cur_byte, out_w, 1'b1);
      oe_q   <= lane_mask(out_w, 1'b1);
      sh_q   <= cur_byte << out_w;
      left_q <= ((left_q == 4'h0) ? 4'(BYTE_W) : left_q) - 4'(out_w);
      if (left_q == 4'h0)
        idx_q <= idx_q + 8'h01;
    end
  end

  assign LINK.d_io_o  = dout_q;
  assign LINK.d_io_oe = oe_q;

endmodule

// [hdl/flash_id_host.sv]
// Purpose: Serial controller that issues identification reads ordered over AHB-Lite
// Assumes: Single word transfers, zero wait states
// Notes:   Link clock is CLK divided by 2*HALF_DIV; HALF_DIV must be at least 3
`timescale 1ns/1ps
module flash_id_host #(
  parameter int HALF_DIV = 4
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic      [31:0] HRDATA,
  output logic             HRESP,
  // Link
  flash_id_if.host         LINK
);
  import flash_id_pkg::*;

  typedef enum logic [1:0] {H_IDLE = 2'h0, H_SETUP = 2'h1, H_RUN = 2'h3, H_STOP = 2'h2} hstate_t;

  hstate_t     st_q;
  phase_t      ph_q;
  phase_t      np;
  logic  [7:0] op_q;
  logic  [7:0] addr_lo_q;
  logic        addr4_q;
  logic        quad_q;
  logic  [1:0] dcf_q;
  logic  [3:0] count_q;
  logic        done_q;
  logic [63:0] rx_q;
  logic [63:0] rx_in;
  logic  [5:0] cnt_q;
  logic  [5:0] len;
  logic [31:0] sh_q;
  logic [31:0] load_val;
  logic  [6:0] bits_q;
  logic  [6:0] bits_nx;
  logic  [6:0] tgt;
  logic  [7:0] div_q;
  logic        sclk_q;
  logic        sel_n_q;
  logic        stop_q;
  logic  [3:0] io_o_q;
  logic  [3:0] io_oe_q;
  logic  [3:0] io_m_q;
  logic  [3:0] io_s_q;
  logic        wr_pend_q;
  logic  [7:0] wa_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_word;
  logic  [2:0] w;
  logic        tick;
  logic        rise;
  logic        fall;
  logic        last;
  logic        drive;
  logic        ahb_go;
  logic        wr_ctrl;
  logic        start;
  logic        set_done;
  logic        clr_done;

  assign ahb_go   = HSEL && HTRANS[1] && HREADY;
  assign wr_ctrl  = wr_pend_q && wa_q == REG_CTRL && st_q == H_IDLE;
  assign start    = wr_ctrl && HWDATA[CTRL_START_BIT];
  assign set_done = st_q == H_STOP && tick;
  assign clr_done = wr_pend_q && wa_q == REG_STATUS && HWDATA[STAT_DONE_BIT];

  assign rd_word = (HADDR[7:0] == REG_CTRL)    ? {19'h0, dcf_q, quad_q, addr4_q, 1'b0, op_q} :
                   (HADDR[7:0] == REG_ADDR)    ? {24'h0, addr_lo_q} :
                   (HADDR[7:0] == REG_COUNT)   ? {28'h0, count_q} :
                   (HADDR[7:0] == REG_STATUS)  ? {30'h0, done_q, st_q != H_IDLE} :
                   (HADDR[7:0] == REG_DATA_HI) ? rx_q[63:32] :
                   (HADDR[7:0] == REG_DATA_LO) ? rx_q[31:0] : 32'h0;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wr_pend_q <= 1'b0;
      wa_q      <= 8'h00;
      rdata_q   <= 32'h0;
      op_q      <= 8'h00;
      addr4_q   <= 1'b0;
      quad_q    <= 1'b0;
      dcf_q     <= 2'h0;
      addr_lo_q <= 8'h00;
      count_q   <= 4'h1;
      done_q    <= 1'b0;
    end else begin
      wr_pend_q <= ahb_go && HWRITE;
      wa_q      <= ahb_go ? HADDR[7:0] : wa_q;
      rdata_q   <= (ahb_go && !HWRITE) ? rd_word : rdata_q;
      done_q    <= set_done | (done_q & ~clr_done);
      if (wr_ctrl) begin
        op_q    <= HWDATA[7:0];
        addr4_q <= HWDATA[CTRL_ADDR4_BIT];
        quad_q  <= HWDATA[CTRL_QUAD_BIT];
        dcf_q   <= HWDATA[CTRL_DCF_LSB +: 2];
      end
      if (wr_pend_q && wa_q == REG_ADDR && st_q == H_IDLE)
        addr_lo_q <= HWDATA[7:0];
      if (wr_pend_q && wa_q == REG_COUNT && st_q == H_IDLE)
        count_q <= HWDATA[3:0];
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRDATA    = rdata_q;
  assign HRESP     = 1'b0;

  // Link engine
  assign tick  = div_q == 8'(HALF_DIV - 1);
  assign rise  = st_q == H_RUN && tick && !sclk_q;
  assign fall  = st_q == H_RUN && tick && sclk_q;
  assign w     = ph_lane(op_q, ph_q, quad_q);
  assign drive = ph_q inside {PH_OPC, PH_ADDR, PH_MODE};
  assign len   = ph_clocks(op_q, ph_q, addr4_q, dcf_q, quad_q);
  assign last  = cnt_q == len - 6'h01;
  assign np    = next_active(op_q, ph_q, addr4_q, dcf_q, quad_q);
  assign tgt   = (count_q == 4'h0 || count_q > 4'h8) ? 7'h40 : {count_q, 3'h0};
  assign bits_nx = bits_q + 7'(w);
  assign rx_in = (w == W1) ? {rx_q[62:0], io_s_q[1]} :
                 (w == W2) ? {rx_q[61:0], io_s_q[1:0]} : {rx_q[59:0], io_s_q};
  // Identity reads send an all-zero address; only the table read carries a start byte
  assign load_val = (ph_q == PH_DUMMY) ? 32'h0 :
                    (np == PH_MODE) ? {MODE_BITS, 24'h0} :
                    (op_q == OP_PARAM_TABLE) ? {16'h0, addr_lo_q, 8'h00} : 32'h0;

  // Returning data passes two flip-flops before it is shifted in
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      io_m_q <= 4'h0;
      io_s_q <= 4'h0;
    end else begin
      io_m_q <= LINK.io;
      io_s_q <= io_m_q;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_q    <= H_IDLE;
      ph_q    <= PH_OPC;
      cnt_q   <= 6'h00;
      sh_q    <= 32'h0;
      bits_q  <= 7'h00;
      div_q   <= 8'h00;
      sclk_q  <= 1'b0;
      sel_n_q <= 1'b1;
      stop_q  <= 1'b0;
      io_o_q  <= 4'h0;
      io_oe_q <= 4'h0;
      rx_q    <= 64'h0;
    end else begin
      div_q <= (st_q == H_IDLE || tick) ? 8'h00 : div_q + 8'h01;
      unique case (st_q)
        H_IDLE: if (start) begin
          st_q    <= H_SETUP;
          sel_n_q <= 1'b0;
          ph_q    <= PH_OPC;
          cnt_q   <= 6'h00;
          bits_q  <= 7'h00;
          stop_q  <= 1'b0;
          rx_q    <= 64'h0;
          sh_q    <= {HWDATA[7:0], 24'h0};
        end
        H_SETUP: begin
          st_q    <= H_RUN;
          io_o_q  <= pins(sh_q[31:24], w, 1'b0);
          io_oe_q <= lane_mask(w, 1'b0);
          sh_q    <= sh_q << w;
        end
        H_RUN: begin
          if (tick)
            sclk_q <= !sclk_q;
          if (rise && ph_q == PH_DATA) begin
            rx_q   <= rx_in;
            bits_q <= bits_nx;
            stop_q <= bits_nx >= tgt;
          end else if (rise) begin
            cnt_q <= last ? 6'h00 : cnt_q + 6'h01;
            if (last) begin
              ph_q <= np;
              sh_q <= load_val;
            end
          end
          if (fall && stop_q) begin
            st_q    <= H_STOP;
            io_oe_q <= 4'h0;
          end else if (fall) begin
            io_o_q  <= pins(sh_q[31:24], w, 1'b0);
            io_oe_q <= drive ? lane_mask(w, 1'b0) : 4'h0;
            sh_q    <= sh_q << w;
          end
        end
        H_STOP: if (tick) begin
          sel_n_q <= 1'b1;
          st_q    <= H_IDLE;
        end
      endcase
    end
  end

  assign LINK.select_n = sel_n_q;
  assign LINK.sclk     = sclk_q;
  assign LINK.h_io_o   = io_o_q;
  assign LINK.h_io_oe  = io_oe_q;

endmodule

// [hdl/flash_id_if.sv]
// Purpose: Serial link between controller and identification readout device
// Assumes: Released wires read high, as with pull-ups
// Notes:   Wire level is resolved here from both ends' enables
`timescale 1ns/1ps
interface flash_id_if;
  logic       select_n;
  logic       sclk;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;

  assign io = (h_io_o & h_io_oe) | (d_io_o & d_io_oe) | ~(h_io_oe | d_io_oe);

  modport dev  (input select_n, input sclk, input io, output d_io_o, output d_io_oe);
  modport host (output select_n, output sclk, output h_io_o, output h_io_oe, input io);
endinterface

// [hdl/flash_id_pkg.sv]
// Purpose: Shared constants, phase coding and decode helpers for the identification readout link
// Assumes: Serial link in mode 0, one, two or four data wires
// Notes:   Both ends derive phase lengths and widths from the same functions
package flash_id_pkg;

  // Instructions
  localparam logic [7:0] OP_MFR_ID        = 8'h90;
  localparam logic [7:0] OP_MFR_ID_DUAL   = 8'h92;
  localparam logic [7:0] OP_MFR_ID_QUAD   = 8'h94;
  localparam logic [7:0] OP_UNIQUE_ID     = 8'h4b;
  localparam logic [7:0] OP_THREE_BYTE_ID = 8'h9f;
  localparam logic [7:0] OP_PARAM_TABLE   = 8'h5a;

  // Upper nibble of the continuous read mode byte must be all ones
  localparam logic [7:0] MODE_BITS        = 8'hf0;
  localparam logic [7:0] FILL_BYTE        = 8'hff;

  // Lane widths
  localparam logic [2:0] W1               = 3'h1;
  localparam logic [2:0] W2               = 3'h2;
  localparam logic [2:0] W4               = 3'h4;

  // Phase lengths in serial clocks
  localparam logic [5:0] CLK_OPC_SPI      = 6'h08;
  localparam logic [5:0] CLK_OPC_QUAD     = 6'h02;
  localparam logic [5:0] CLK_PRE_QUAD     = 6'h04;
  localparam logic [5:0] ADDR_BITS_3B     = 6'h18;
  localparam logic [5:0] ADDR_BITS_4B     = 6'h20;
  localparam logic [5:0] MODE_CLK_DUAL    = 6'h04;
  localparam logic [5:0] MODE_CLK_QUAD    = 6'h02;
  localparam logic [5:0] DUMMY_DUAL       = 6'h04;
  localparam logic [5:0] DUMMY_QUAD       = 6'h06;
  localparam logic [5:0] DUMMY_LONG       = 6'h08;
  localparam logic [5:0] UID_DUMMY_3B     = 6'h20;
  localparam logic [5:0] UID_DUMMY_4B     = 6'h28;
  localparam logic [5:0] TABLE_DUMMY      = 6'h08;
  localparam logic [5:0] DATA_CLKS        = 6'h3f;
  localparam int         DCF_LONG_BIT     = 0;
  localparam int         BYTE_W           = 8;
  localparam int         TABLE_BYTES      = 256;

  // Controller register map
  localparam logic [7:0] REG_CTRL         = 8'h00;
  localparam logic [7:0] REG_ADDR         = 8'h04;
  localparam logic [7:0] REG_COUNT        = 8'h08;
  localparam logic [7:0] REG_STATUS       = 8'h0c;
  localparam logic [7:0] REG_DATA_HI      = 8'h10;
  localparam logic [7:0] REG_DATA_LO      = 8'h14;
  localparam int         CTRL_START_BIT   = 8;
  localparam int         CTRL_ADDR4_BIT   = 9;
  localparam int         CTRL_QUAD_BIT    = 10;
  localparam int         CTRL_DCF_LSB     = 11;
  localparam int         STAT_BUSY_BIT    = 0;
  localparam int         STAT_DONE_BIT    = 1;

  typedef enum logic [2:0] {
    PH_OPC    = 3'h0,
    PH_PRE    = 3'h1,
    PH_ADDR   = 3'h3,
    PH_MODE   = 3'h2,
    PH_DUMMY  = 3'h6,
    PH_DATA   = 3'h7,
    PH_IGNORE = 3'h5
  } phase_t;

  function automatic logic op_ok(input logic [7:0] op, input logic quad);
    if (quad)
      return op == OP_THREE_BYTE_ID;
    return op inside {OP_MFR_ID, OP_MFR_ID_DUAL, OP_MFR_ID_QUAD, OP_UNIQUE_ID,
                      OP_THREE_BYTE_ID, OP_PARAM_TABLE};
  endfunction

  function automatic phase_t next_ph(input phase_t ph);
    case (ph)
      PH_OPC:   return PH_PRE;
      PH_PRE:   return PH_ADDR;
      PH_ADDR:  return PH_MODE;
      PH_MODE:  return PH_DUMMY;
      default:  return ph == PH_IGNORE ? PH_IGNORE : PH_DATA;
    endcase
  endfunction

  // Zero means the instruction has no such phase
  function automatic logic [5:0] ph_clocks(input logic [7:0] op, input phase_t ph, input logic addr4,
                                           input logic [1:0] dcf, input logic quad);
    logic       lng;
    logic [5:0] a;
    lng = dcf[DCF_LONG_BIT];
    a   = (addr4 && op != OP_MFR_ID) ? ADDR_BITS_4B : ADDR_BITS_3B;
    case (ph)
      PH_OPC:   return quad ? CLK_OPC_QUAD : CLK_OPC_SPI;
      PH_PRE:   return (op == OP_MFR_ID_QUAD) ? CLK_PRE_QUAD : 6'h00;
      PH_ADDR:  return (op == OP_MFR_ID) ? ADDR_BITS_3B : (op == OP_PARAM_TABLE) ? ADDR_BITS_3B :
                       (op == OP_MFR_ID_DUAL) ? (a >> 1) : (op == OP_MFR_ID_QUAD) ? (a >> 2) : 6'h00;
      PH_MODE:  return (op == OP_MFR_ID_DUAL) ? MODE_CLK_DUAL :
                       (op == OP_MFR_ID_QUAD) ? MODE_CLK_QUAD : 6'h00;
      PH_DUMMY: return (op == OP_MFR_ID_DUAL) ? (lng ? DUMMY_LONG : DUMMY_DUAL) - MODE_CLK_DUAL :
                       (op == OP_MFR_ID_QUAD) ? (lng ? DUMMY_LONG : DUMMY_QUAD) - MODE_CLK_QUAD :
                       (op == OP_UNIQUE_ID) ? (addr4 ? UID_DUMMY_4B : UID_DUMMY_3B) :
                       (op == OP_PARAM_TABLE) ? TABLE_DUMMY : 6'h00;
      default:  return DATA_CLKS;
    endcase
  endfunction

  function automatic logic [2:0] ph_lane(input logic [7:0] op, input phase_t ph, input logic quad);
    if (ph == PH_OPC || op == OP_THREE_BYTE_ID)
      return quad ? W4 : W1;
    if (op == OP_MFR_ID_DUAL)
      return W2;
    return (op == OP_MFR_ID_QUAD) ? W4 : W1;
  endfunction

  function automatic phase_t next_active(input logic [7:0] op, input phase_t ph, input logic addr4,
                                         input logic [1:0] dcf, input logic quad);
    phase_t p;
    p = next_ph(ph);
    for (int i = 0; i < 4; i++) begin
      if (p != PH_DATA && ph_clocks(op, p, addr4, dcf, quad) == 6'h00)
        p = next_ph(p);
    end
    return p;
  endfunction

  // Input lanes enter at the low end, wire 1 above wire 0
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic [3:0] b, input logic [2:0] w);
    return (w == W1) ? {v[6:0], b[0]} : (w == W2) ? {v[5:0], b[1:0]} : {v[3:0], b};
  endfunction

  // Single-wire traffic uses wire 1 when pin1 is set, else wire 0
  function automatic logic [3:0] pins(input logic [7:0] v, input logic [2:0] w, input logic pin1);
    return (w == W4) ? v[7:4] : (w == W2) ? {2'h0, v[7:6]} : pin1 ? {2'h0, v[7], 1'b0} : {3'h0, v[7]};
  endfunction

  function automatic logic [3:0] lane_mask(input logic [2:0] w, input logic pin1);
    return (w == W4) ? 4'hf : (w == W2) ? 4'h3 : pin1 ? 4'h2 : 4'h1;
  endfunction

endpackage

// [verification/flash_id_assertions.sv]
// Purpose: Link protocol checks for the identification readout
// Assumes: Controller clock outruns the link clock
// Notes:   Per-opcode latency is left to the bench model
`timescale 1ns/1ps
module flash_id_assertions (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RESET,
  // Link
  input wire logic       select_n,
  input wire logic       sclk,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] d_io_o,
  input wire logic [3:0] d_io_oe
);
  logic [5:0] rises_q;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // Saturates so a long frame cannot wrap back into the quiet window
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET || select_n)
      rises_q <= 6'h00;
    else if ($rose(sclk) && rises_q != 6'h3f)
      rises_q <= rises_q + 6'h01;
  end
  AST_QUIET_DESELECTED: assert property (select_n |-> d_io_oe == 4'h0)
    else $error("drive while deselected");
  AST_CHANGE_ON_FALL: assert property (!select_n && $changed(d_io_o & d_io_oe) |-> $fell(sclk))
    else $error("output moved off a falling edge");
  AST_HELD_WHILE_HIGH: assert property (!select_n && sclk |-> $stable(d_io_o & d_io_oe))
    else $error("output moved while clock high");
  AST_LANE_SET: assert property (d_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("bad lane set");
  AST_NO_CONTENTION: assert property ((h_io_oe & d_io_oe) == 4'h0)
    else $error("both ends drive a wire");
  AST_SELECT_CLOCK_LOW: assert property ($changed(select_n) |-> !sclk)
    else $error("select moved with clock high");
  AST_FRAME_ENDS: assert property ($fell(select_n) |-> ##[1:1000] $rose(select_n))
    else $error("frame not closed in time");
  AST_OPCODE_QUIET: assert property (rises_q < 6'h02 |-> d_io_oe == 4'h0)
    else $error("drive during opcode");
  CV_SINGLE: cover property (d_io_oe == 4'h2);
  CV_DUAL: cover property (d_io_oe == 4'h3);
  CV_QUAD: cover property (d_io_oe == 4'hf);
endmodule

// [verification/tb_top.sv]
// Purpose: Bench for controller and readout device on one link
// Assumes: Straps follow the CTRL bits; one warm-up frame after each change
// Notes:   Only the bytes a frame fetched are compared
`timescale 1ns/1ps
module tb_top;
  import flash_id_pkg::*;
  // Identity values are arbitrary
  localparam logic [7:0]  MFR = 8'h3c;
  localparam logic [7:0]  DEV = 8'h5e;
  localparam logic [7:0]  TYP = 8'h71;
  localparam logic [7:0]  CAP = 8'h1a;
  localparam logic [63:0] UID = 64'hfe12_dc34_ba56_9870;
  logic        clk;
  logic        rst    = 1'b1;
  logic        a4     = 1'b0;
  logic        q      = 1'b0;
  logic [1:0]  dcf    = 2'h0;
  logic [31:0] haddr  = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [7:0]  lf     = 8'h44;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [7:0]  last_op;
  logic [31:0] r;
  int          num_errors = 0;
  int          n_checks   = 0;
  logic [7:0]  ops[6] = '{OP_MFR_ID, OP_MFR_ID_DUAL, OP_MFR_ID_QUAD, OP_UNIQUE_ID, OP_THREE_BYTE_ID, OP_PARAM_TABLE};
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [7:0] tb_b(input int n);
    return 8'(n * 7 + 3);
  endfunction
  function automatic logic [2047:0] mk_tbl();
    for (int n = 0; n < 256; n++)
      mk_tbl[8*n +: 8] = tb_b(n);
  endfunction
  flash_id_if lk ();
  flash_id_host #(.HALF_DIV(3)) i_flash_id_host (.CLK(clk), .RESET(rst), .HSEL(1'b1), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
    .HRDATA(hrdata), .HRESP(hresp), .LINK(lk.host));
  flash_id_device #(.MFR_ID_VAL(MFR), .DEV_ID_VAL(DEV), .TYPE_VAL(TYP), .CAPACITY_VAL(CAP), .UNIQUE_ID(UID),
    .PARAM_TABLE(mk_tbl())) i_flash_id_device (.RESET(rst), .LINK(lk.dev), .DUMMY_COUNT_FIELD(dcf),
    .FOUR_WIRE_COMMAND_MODE(q), .ADDR4_MODE(a4), .LAST_OPCODE(last_op));
  flash_id_assertions i_flash_id_assertions (.CLK(clk), .RESET(rst), .select_n(lk.select_n), .sclk(lk.sclk),
    .h_io_oe(lk.h_io_oe), .d_io_o(lk.d_io_o), .d_io_oe(lk.d_io_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task give_verdict();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task hang();
    num_errors++;
    give_verdict();
  endtask
  task check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Entered just after a rising edge; waits out a slave stall, giving up after 64 cycles
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n = 0;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    rd = hrdata;
    if (n >= 64)
      hang();
  endtask
  function automatic logic [7:0] exp_byte(input logic [7:0] op, input int i, input logic [7:0] ad);
    if (q && op != OP_THREE_BYTE_ID)
      return 8'hff;
    case (op)
      OP_THREE_BYTE_ID: return (i == 0) ? MFR : (i == 1) ? TYP : (i == 2) ? CAP : 8'hff;
      OP_UNIQUE_ID:     return UID[63 - 8 * (i % 8) -: 8];
      OP_PARAM_TABLE:   return tb_b((ad + i) % 256);
      default:          return (i % 2) ? DEV : MFR;
    endcase
  endfunction
  task automatic run(input logic [7:0] op, input bit chk);
    logic [31:0] hi;
    logic [7:0]  ad;
    logic [3:0]  cnt;
    logic [63:0] ex = 64'h0;
    logic [7:0]  eq[$];
    int          g  = 0;
    lf  = lfsr(lf);
    ad  = lf;
    cnt = (op == OP_UNIQUE_ID) ? 4'h8 : {1'b0, lf[6:4]} + 4'h1;
    ahb(1'b1, REG_ADDR, {24'h0, ad}, r);
    ahb(1'b1, REG_COUNT, {28'h0, cnt}, r);
    ahb(1'b1, REG_CTRL, {19'h0, dcf, q, a4, 1'b1, op}, r);
    do begin
      ahb(1'b0, REG_STATUS, 32'h0, r);
      g++;
    end while (r[STAT_DONE_BIT] !== 1'b1 && g < 1000);
    if (g >= 1000)
      hang();
    ahb(1'b1, REG_STATUS, 32'h2, r);
    ahb(1'b0, REG_DATA_HI, 32'h0, hi);
    ahb(1'b0, REG_DATA_LO, 32'h0, r);
    for (int i = 0; i < cnt; i++)
      eq.push_back(exp_byte(op, i, ad));
    foreach (eq[i])
      ex = {ex[55:0], eq[i]};
    if (chk) begin
      check({hi, r} & ((cnt == 4'h8) ? '1 : (64'h1 << (8 * cnt)) - 64'h1), ex);
      check({59'h0, lk.select_n, lk.d_io_oe}, {59'h0, 1'b1, 4'h0});
      check({55'h0, hresp, last_op}, {55'h0, 1'b0, op});
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    ahb(1'b1, 8'h20, 32'hdead_beef, r);
    ahb(1'b0, 8'h20, 32'h0, r);
    check({32'h0, r}, 64'h0);
    for (int c = 0; c < 8; c++) begin
      a4  <= c[0];
      dcf <= c[2:1];
      q   <= c[2] & ~c[0];
      run(OP_THREE_BYTE_ID, 1'b0);
      foreach (ops[k])
        run(ops[k], 1'b1);
    end
    give_verdict();
  end
endmodule
